// ===== plane_flip_regs.svh
/*
 * Offsets, field positions, reset values and masks of the secondary plane
 * surface and flip register set.
 * Assumes a 32-bit memory-mapped register port and a command-packet port.
 */
`ifndef PLANE_FLIP_REGS_SVH
`define PLANE_FLIP_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_LINEAR_OFFSET 32'h0007_1184
`define OFS_STRIDE        32'h0007_1188
`define OFS_KEY_VALUE     32'h0007_1194
`define OFS_KEY_MASK      32'h0007_1198
`define OFS_SURFACE_BASE  32'h0007_119C
`define OFS_TILED_OFFSET  32'h0007_11A4
`define OFS_LIVE_SURFACE  32'h0007_11AC
`define OFS_FLIPQ_STATUS  32'h0007_1200
`define OFS_LEGACY_VIDEO  32'h0007_1400

// ****************************************************************
// Writable bit masks, field positions and reset value
// ****************************************************************
`define MSK_STRIDE        32'hFFFF_FFC0
`define MSK_KEY           32'h00FF_FFFF
`define MSK_SURFACE       32'hFFFF_F008
`define MSK_TILED         32'h0FFF_0FFF
`define BIT_FLIP_SOURCE   3
`define BIT_CTRL_TILED    10
`define BIT_CTRL_ASYNC    9
`define RST_REG           32'h0000_0000

`endif

// ===== plane_flip_pkg.sv
/*
 * Types of the secondary plane flip register set.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package plane_flip_pkg;
  // Origin of a register write
  typedef enum logic [0:0] {
    SRC_MMIO = 1'b0,
    SRC_CMD  = 1'b1
  } write_src_t;
endpackage

// ===== plane_surface_flip_registers.sv
/*
 * Double-buffered surface, panning, stride and color key registers of a
 * secondary plane, with live surface and flip queue status readback.
 * Assumes vsync/vblank pulses are one cycle on clk_in, plane control bits
 * come from the plane control register, and the flip queue counts come
 * from the queue logic on the same clock.
 */
`timescale 1ns/1ps
`include "plane_flip_regs.svh"
module plane_surface_flip_registers
  import plane_flip_pkg::*;
#(
  parameter int CW = 8
)(
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  input  wire logic          mmio_wr_in,
  input  wire logic          mmio_rd_in,
  input  wire logic [31:0]   mmio_addr_in,
  input  wire logic [31:0]   mmio_wdata_in,
  output logic      [31:0]   mmio_rdata_out,
  input  wire logic          cmd_wr_in,
  input  wire logic [31:0]   cmd_addr_in,
  input  wire logic [31:0]   cmd_wdata_in,
  input  wire logic          vsync_in,
  input  wire logic          vblank_in,
  input  wire logic          ctrl_tiled_in,
  input  wire logic          ctrl_async_in,
  input  wire logic          key_enable_in,
  input  wire logic [CW-1:0] queue_free_in,
  input  wire logic [CW-1:0] queue_used_in,
  input  wire logic [23:0]   pixel_in,
  output logic      [31:0]   start_addr_out,
  output logic      [11:0]   start_x_out,
  output logic      [11:0]   start_y_out,
  output logic      [25:0]   stride_out,
  output logic               key_match_out,
  output logic               flip_done_render_out,
  output logic               flip_done_blit_out
);

  // ****************************************************************
  // Write port merge
  // ****************************************************************
  // Software wins a same-cycle collision; command packets are replayable
  wire write_src_t src_sel  = mmio_wr_in ? SRC_MMIO : SRC_CMD;
  wire logic        wr_any  = mmio_wr_in | cmd_wr_in;
  wire logic [31:0] wr_addr = (src_sel == SRC_MMIO) ? mmio_addr_in
                                                    : cmd_addr_in;
  wire logic [31:0] wr_data = (src_sel == SRC_MMIO) ? mmio_wdata_in
                                                    : cmd_wdata_in;

  // Decode and masked write data; reserved bits never stored
  wire logic we_lin  = wr_any && (wr_addr == `OFS_LINEAR_OFFSET);
  wire logic we_str  = wr_any && (wr_addr == `OFS_STRIDE);
  wire logic we_kv   = wr_any && (wr_addr == `OFS_KEY_VALUE);
  wire logic we_km   = wr_any && (wr_addr == `OFS_KEY_MASK);
  wire logic we_surf = wr_any && (wr_addr == `OFS_SURFACE_BASE);
  wire logic we_tile = wr_any && (wr_addr == `OFS_TILED_OFFSET);
  wire logic we_leg  = mmio_wr_in && (mmio_addr_in == `OFS_LEGACY_VIDEO);

  // ****************************************************************
  // Pending and active copies
  // ****************************************************************
  logic [31:0] lin_p_q, lin_a_q, str_p_q, str_a_q;
  logic [31:0] kv_p_q, kv_a_q, km_p_q, km_a_q;
  logic [31:0] surf_p_q, surf_a_q, tile_p_q, tile_a_q, leg_q;
  logic        armed_q;
  logic        async_flip;
  logic        sync_flip;

  // Async surface updates apply immediately for software writes only
  assign async_flip = we_surf && ctrl_async_in &&
                      (src_sel == SRC_MMIO);
  assign sync_flip  = armed_q && vblank_in;

  // Pending copies take writes at any time
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lin_p_q  <= `RST_REG;
      str_p_q  <= `RST_REG;
      kv_p_q   <= `RST_REG;
      km_p_q   <= `RST_REG;
      surf_p_q <= `RST_REG;
      tile_p_q <= `RST_REG;
      leg_q    <= `RST_REG;
    end
    else
    begin
      if (we_lin)  lin_p_q  <= wr_data;
      if (we_str)  str_p_q  <= wr_data & `MSK_STRIDE;
      if (we_kv)   kv_p_q   <= wr_data & `MSK_KEY;
      if (we_km)   km_p_q   <= wr_data & `MSK_KEY;
      if (we_surf) surf_p_q <= wr_data & `MSK_SURFACE;
      if (we_tile) tile_p_q <= wr_data & `MSK_TILED;
      if (we_leg)  leg_q    <= mmio_wdata_in;
    end
  end

  // Flip arm: a new surface write other than an async flip during the vblank edge rearms (set wins)
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      armed_q <= 1'b0;
    else if (we_surf && !async_flip)
      armed_q <= 1'b1;
    else if (sync_flip || async_flip)
      armed_q <= 1'b0;
  end

  // Linear offset by vsync, tiled offset by vblank, others on a vblank flip; surface also on an async flip
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lin_a_q  <= `RST_REG;
      tile_a_q <= `RST_REG;
      str_a_q  <= `RST_REG;
      kv_a_q   <= `RST_REG;
      km_a_q   <= `RST_REG;
      surf_a_q <= `RST_REG;
    end
    else
    begin
      if (vsync_in)  lin_a_q  <= lin_p_q;
      if (vblank_in) tile_a_q <= tile_p_q;
      if (sync_flip)
      begin
        str_a_q <= str_p_q;
        kv_a_q  <= kv_p_q;
        km_a_q  <= km_p_q;
      end
      if (async_flip)
        surf_a_q <= wr_data & `MSK_SURFACE;
      else if (sync_flip)
        surf_a_q <= surf_p_q;
    end
  end

  // ****************************************************************
  // Derived plane outputs
  // ****************************************************************
  // Base is an aperture offset; the translation table lookup sits
  // downstream, so only the aperture-relative address leaves here
  wire logic [31:0] base_addr = {surf_a_q[31:12], 12'h000};
  wire logic [31:0] start_d = ctrl_tiled_in ? base_addr
                                : base_addr + lin_a_q;
  wire logic [11:0] x_d = ctrl_tiled_in ? tile_a_q[11:0]  : 12'h000;
  wire logic [11:0] y_d = ctrl_tiled_in ? tile_a_q[27:16] : 12'h000;

  // Key compare: mismatch bits count only where the mask is set
  function automatic logic key_hit(input logic [23:0] px,
                                   input logic [23:0] kv,
                                   input logic [23:0] km);
    key_hit = ((px ^ kv) & km) == 24'h00_0000;
  endfunction
  wire logic match_d = key_enable_in &&
                       key_hit(pixel_in, kv_a_q[23:0], km_a_q[23:0]);

  // Flip done follows the source bit of the surface that just went live
  wire logic done_any = sync_flip || async_flip;
  wire logic src_bit  = async_flip ? wr_data[`BIT_FLIP_SOURCE]
                                   : surf_p_q[`BIT_FLIP_SOURCE];

  // Registered data outputs
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      start_addr_out       <= `RST_REG;
      start_x_out          <= 12'h000;
      start_y_out          <= 12'h000;
      stride_out           <= 26'h000_0000;
      key_match_out        <= 1'b0;
      flip_done_render_out <= 1'b0;
      flip_done_blit_out   <= 1'b0;
    end
    else
    begin
      start_addr_out       <= start_d;
      start_x_out          <= x_d;
      start_y_out          <= y_d;
      stride_out           <= str_a_q[31:6];
      key_match_out        <= match_d;
      flip_done_render_out <= done_any && !src_bit;
      flip_done_blit_out   <= done_any && src_bit;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Pending copies read back so software sees what it last wrote
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (mmio_addr_in)
      `OFS_LINEAR_OFFSET: rd_mux = lin_p_q;
      `OFS_STRIDE:        rd_mux = str_p_q;
      `OFS_KEY_VALUE:     rd_mux = kv_p_q;
      `OFS_KEY_MASK:      rd_mux = km_p_q;
      `OFS_SURFACE_BASE:  rd_mux = surf_p_q;
      `OFS_TILED_OFFSET:  rd_mux = tile_p_q;
      `OFS_LIVE_SURFACE:  rd_mux = surf_a_q & `MSK_SURFACE;
      `OFS_FLIPQ_STATUS:  rd_mux = {16'h0000, 8'(queue_free_in),
                                    8'(queue_used_in)};
      `OFS_LEGACY_VIDEO:  rd_mux = leg_q;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured on the read strobe, valid next cycle
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mmio_rdata_out <= `RST_REG;
    else if (mmio_rd_in)
      mmio_rdata_out <= rd_mux;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_lin_vsync;
    @(posedge clk_in) disable iff (!arst_n_in)
    vsync_in |=> lin_a_q == $past(lin_p_q);
  endproperty
  a_lin_vsync: assert property (p_lin_vsync)
    else $error("linear offset not applied at vsync");

  property p_lin_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
    !vsync_in |=> $stable(lin_a_q);
  endproperty
  a_lin_hold: assert property (p_lin_hold)
    else $error("linear offset changed without vsync");

  property p_tile_vblank;
    @(posedge clk_in) disable iff (!arst_n_in)
    !vblank_in |=> $stable(tile_a_q);
  endproperty
  a_tile_vblank: assert property (p_tile_vblank)
    else $error("tiled offset changed outside vblank");

  property p_start_tiled;
    @(posedge clk_in) disable iff (!arst_n_in)
    ctrl_tiled_in |=> start_addr_out == {$past(surf_a_q[31:12]), 12'h000};
  endproperty
  a_start_tiled: assert property (p_start_tiled)
    else $error("tiled start used linear offset");

  property p_start_linear;
    @(posedge clk_in) disable iff (!arst_n_in)
    !ctrl_tiled_in |=> start_x_out == 12'h000 &&
      start_addr_out == {$past(surf_a_q[31:12]), 12'h000} + $past(lin_a_q);
  endproperty
  a_start_linear: assert property (p_start_linear)
    else $error("linear start address wrong");

  property p_flip_arm;
    @(posedge clk_in) disable iff (!arst_n_in)
    armed_q && vblank_in && !async_flip |=> surf_a_q == $past(surf_p_q);
  endproperty
  a_flip_arm: assert property (p_flip_arm)
    else $error("armed flip not applied at vblank");

  property p_flip_route;
    @(posedge clk_in) disable iff (!arst_n_in)
    sync_flip && !async_flip |=>
      flip_done_blit_out == $past(surf_p_q[3]) &&
      flip_done_render_out == !$past(surf_p_q[3]);
  endproperty
  a_flip_route: assert property (p_flip_route)
    else $error("flip done routed to wrong streamer");

  property p_key_off;
    @(posedge clk_in) disable iff (!arst_n_in)
    !key_enable_in |=> !key_match_out;
  endproperty
  a_key_off: assert property (p_key_off)
    else $error("key match while keying disabled");

  property p_queue;
    @(posedge clk_in) disable iff (!arst_n_in)
    mmio_rd_in && mmio_addr_in == `OFS_FLIPQ_STATUS |=>
      mmio_rdata_out[15:8] == 8'($past(queue_free_in)) &&
      mmio_rdata_out[7:0] == 8'($past(queue_used_in)) &&
      mmio_rdata_out[31:16] == 16'h0000;
  endproperty
  a_queue: assert property (p_queue)
    else $error("queue status readback wrong");

  c_sync_flip:  cover property (@(posedge clk_in) sync_flip);
  c_async_flip: cover property (@(posedge clk_in) async_flip);
  c_key_match:  cover property (@(posedge clk_in) key_match_out);
  c_cmd_write:  cover property (@(posedge clk_in)
                                cmd_wr_in && !mmio_wr_in && we_surf);

endmodule // plane_surface_flip_registers

// ===== cmd_stream_model.sv
/* Command streamer model: sends a stride packet, then a surface packet.
   Assumes go_in is a one-cycle pulse given only while busy_out is low. */
`timescale 1ns/1ps
`include "plane_flip_regs.svh"
module cmd_stream_model
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        go_in,
  input  wire logic        tiled_in,
  input  wire logic [3:0]  gap_in,
  input  wire logic [31:0] stride_in,
  input  wire logic [31:0] surf_in,
  output logic             cmd_wr_out,
  output logic [31:0]      cmd_addr_out,
  output logic [31:0]      cmd_wdata_out,
  output logic             busy_out
);
  // ************************************************************
  // Packet sequencer
  // ************************************************************
  logic [31:0] stride_a;
  logic [3:0]  wait_q;
  logic        step_q;

  // Tiled pitch is kept 512-aligned and below 16K, linear 64-aligned
  assign stride_a = tiled_in ? {18'h0, stride_in[13:9], 9'h0}
                             : {stride_in[31:6], 6'h0};
  assign busy_out = step_q | cmd_wr_out;

  // Stride goes first, as the surface packet is what arms the flip
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      step_q        <= 1'b0;
      wait_q        <= 4'h0;
      cmd_wr_out    <= 1'b0;
      cmd_addr_out  <= 32'h0;
      cmd_wdata_out <= 32'h0;
    end
    else if (cmd_wr_out)
    begin
      cmd_wr_out    <= 1'b0;
      cmd_addr_out  <= ~cmd_addr_out;   // Released bus shows no stale word
      cmd_wdata_out <= ~cmd_wdata_out;
    end
    else if (!step_q && go_in)
    begin
      step_q        <= 1'b1;
      wait_q        <= gap_in;          // Zero gap is prompt, else slow
      cmd_wr_out    <= 1'b1;
      cmd_addr_out  <= `OFS_STRIDE;
      cmd_wdata_out <= stride_a;
    end
    else if (step_q && wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else if (step_q)
    begin
      step_q        <= 1'b0;
      cmd_wr_out    <= 1'b1;
      cmd_addr_out  <= `OFS_SURFACE_BASE;
      cmd_wdata_out <= {surf_in[31:12], 8'h0, surf_in[3], 3'h0};
    end
endmodule // cmd_stream_model

// ===== plane_surface_flip_registers_bench.sv
/* Self-checking bench of the plane surface flip registers.
   Assumes the register header and the command streamer model. */
`timescale 1ns/1ps
`include "plane_flip_regs.svh"
module plane_surface_flip_registers_bench;
  // ************************************************************
  // Signals, instances and shared tasks
  // ************************************************************
  logic        clk_in, arst_n_in, mmio_wr_in, mmio_rd_in, cmd_wr_in, go;
  logic        vsync_in, vblank_in, ctrl_tiled_in, ctrl_async_in, busy;
  logic        key_enable_in, key_match_out, rd_seen;
  logic        flip_done_render_out, flip_done_blit_out;
  logic [31:0] mmio_addr_in, mmio_wdata_in, mmio_rdata_out, cmd_addr_in;
  logic [31:0] cmd_wdata_in, start_addr_out, strd, surf, se, lin, tv, km;
  logic [25:0] stride_out;
  logic [23:0] pixel_in;
  logic [11:0] start_x_out, start_y_out;
  logic [7:0]  queue_free_in, queue_used_in;
  logic [3:0]  rend, blit, gap;
  logic [31:0] exp_q[$];
  logic [31:0] wv[10];
  int          fail_count, n_compared, cycles;
  logic [31:0] ofs[10] = '{`OFS_LINEAR_OFFSET, `OFS_STRIDE, `OFS_KEY_VALUE,
    `OFS_KEY_MASK, `OFS_SURFACE_BASE, `OFS_TILED_OFFSET, `OFS_LIVE_SURFACE,
    `OFS_FLIPQ_STATUS, `OFS_LEGACY_VIDEO, 32'h0007_1190};
  logic [31:0] msk[10] = '{32'hFFFF_FFFF, `MSK_STRIDE, `MSK_KEY, `MSK_KEY,
    `MSK_SURFACE, `MSK_TILED, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0};

  plane_surface_flip_registers #(.CW(8)) plane_surface_flip_registers_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .mmio_wr_in(mmio_wr_in),
    .mmio_rd_in(mmio_rd_in), .mmio_addr_in(mmio_addr_in),
    .mmio_wdata_in(mmio_wdata_in), .mmio_rdata_out(mmio_rdata_out),
    .cmd_wr_in(cmd_wr_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .vsync_in(vsync_in), .vblank_in(vblank_in),
    .ctrl_tiled_in(ctrl_tiled_in), .ctrl_async_in(ctrl_async_in),
    .key_enable_in(key_enable_in), .queue_free_in(queue_free_in),
    .queue_used_in(queue_used_in), .pixel_in(pixel_in),
    .start_addr_out(start_addr_out), .start_x_out(start_x_out),
    .start_y_out(start_y_out), .stride_out(stride_out),
    .key_match_out(key_match_out),
    .flip_done_render_out(flip_done_render_out),
    .flip_done_blit_out(flip_done_blit_out));

  cmd_stream_model cmd_stream_model_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go),
    .tiled_in(ctrl_tiled_in), .gap_in(gap), .stride_in(strd),
    .surf_in(surf), .cmd_wr_out(cmd_wr_in), .cmd_addr_out(cmd_addr_in),
    .cmd_wdata_out(cmd_wdata_in), .busy_out(busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Inputs move 1 ns after the edge so no sample races the drive
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One idle cycle after each strobe keeps one assignment per time step
  task automatic mmio_write(input logic [31:0] a, input logic [31:0] d);
    mmio_wr_in = 1'b1;
    mmio_addr_in = a;
    mmio_wdata_in = d;
    tick(1);
    mmio_wr_in = 1'b0;
    tick(1);
  endtask

  task automatic mmio_read(input logic [31:0] a, input logic [31:0] e);
    mmio_rd_in = 1'b1;
    mmio_addr_in = a;
    exp_q.push_back(e);
    tick(1);
    mmio_rd_in = 1'b0;
    tick(1);
  endtask

  task automatic pulse(input bit vb);
    if (vb)
      vblank_in = 1'b1;
    else
      vsync_in = 1'b1;
    tick(1);
    vblank_in = 1'b0;
    vsync_in = 1'b0;
    tick(3);
  endtask

  // ************************************************************
  // Clock, watchdog and read-data monitor
  // ************************************************************
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // A hang is cut short well past the expected two hundred or fewer cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // Read data lands one cycle after the read edge; match the oldest note
  always @(posedge clk_in)
  begin
    if (rd_seen)
      check(mmio_rdata_out, exp_q.pop_front());
    rd_seen = mmio_rd_in;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {arst_n_in, mmio_wr_in, mmio_rd_in, go, vsync_in, vblank_in} = '0;
    {ctrl_tiled_in, ctrl_async_in, key_enable_in, rd_seen} = '0;
    {mmio_addr_in, mmio_wdata_in, strd, surf, pixel_in, gap} = '0;
    {queue_free_in, queue_used_in, fail_count, n_compared, cycles} = '0;
    void'($urandom(62));
    repeat (16) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    // Reset values, then masked write-back incl. read-only and unmapped
    foreach (ofs[i])
      mmio_read(ofs[i], 32'h0);
    foreach (ofs[i])
    begin
      wv[i] = $urandom();
      mmio_write(ofs[i], wv[i]);
    end
    foreach (ofs[i])
      mmio_read(ofs[i], wv[i] & msk[i]);
    // Packet flips, slow then prompt; the source bit picks the done path
    for (int s = 1; s >= 0; s--)
    begin
      strd = $urandom();
      surf = $urandom();
      surf[3] = s[0];
      gap = s[0] ? 4'h7 : 4'h0;
      ctrl_tiled_in = s[0];           // Slow flip also takes the tiled pitch
      se = {surf[31:12], 8'h0, surf[3], 3'h0};
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (int k = 0; k < 20 && busy; k++)
        tick(1);
      mmio_read(`OFS_LIVE_SURFACE, s ? 32'h0 : tv);
      {rend, blit} = '0;
      vblank_in = 1'b1;
      repeat (4)
      begin
        tick(1);
        vblank_in = 1'b0;
        rend = rend + 4'(flip_done_render_out);
        blit = blit + 4'(flip_done_blit_out);
      end
      check(32'({rend, blit}), s ? 32'h01 : 32'h10);
      check(32'(stride_out), s ? 32'({strd[13:9], 3'h0})
                               : 32'(strd[31:6]));
      mmio_read(`OFS_LIVE_SURFACE, se);
      tv = se;
    end
    // Linear pan waits for vsync and adds to the base
    lin = $urandom() & 32'h00FF_FFFC;
    mmio_write(`OFS_LINEAR_OFFSET, lin);
    pulse(1'b0);
    check(start_addr_out, se + lin);
    mmio_write(`OFS_LINEAR_OFFSET, lin + 32'h40);
    tick(4);
    check(start_addr_out, se + lin);
    pulse(1'b0);
    check(start_addr_out, se + lin + 32'h40);
    // Tiled mode drops the linear pan; tiled pan waits for vblank
    ctrl_tiled_in = 1'b1;
    tick(3);
    check(start_addr_out, se);
    check(32'({start_y_out, start_x_out}), 32'({wv[5][27:16], wv[5][11:0]}));
    tv = $urandom();
    mmio_write(`OFS_TILED_OFFSET, tv);
    pulse(1'b0);
    check(32'(start_x_out), 32'(wv[5][11:0]));
    pulse(1'b1);
    check(32'({start_y_out, start_x_out}), 32'({tv[27:16], tv[11:0]}));
    ctrl_tiled_in = 1'b0;
    tick(3);
    check(32'({start_y_out, start_x_out}), 32'h0);
    // Key and mask switch at the flip; masked-off bits never spoil a match
    lin = $urandom();
    km = $urandom() | 32'h1;
    mmio_write(`OFS_KEY_VALUE, lin);
    mmio_write(`OFS_KEY_MASK, km);
    mmio_write(`OFS_SURFACE_BASE, se);
    pulse(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      key_enable_in = (i < 6);
      pixel_in = 24'((lin & km) | ($urandom() & ~km)) ^
                 (i[0] ? 24'h0 : 24'(km & -km));
      tick(1);
      check(32'(key_match_out), 32'(i < 6 && i[0]));
    end
    // Queue counts are sampled at the read
    repeat (3)
    begin
      {queue_free_in, queue_used_in} = 16'($urandom());
      tick(1);
      mmio_read(`OFS_FLIPQ_STATUS, {16'h0, queue_free_in, queue_used_in});
    end
    // Async mode lets a software surface write land with no vblank
    ctrl_async_in = 1'b1;
    surf = $urandom() & 32'hFFFF_F000;
    mmio_write(`OFS_SURFACE_BASE, surf);
    tick(1);
    mmio_read(`OFS_LIVE_SURFACE, surf);
    ctrl_async_in = 1'b0;
    tick(2);
    end_sim();
  end
endmodule // plane_surface_flip_registers_bench
